// file: hdl/ifram_defines.svh
// Constants for the two-wire byte memory slave
`ifndef IFRAM_DEFINES_SVH
`define IFRAM_DEFINES_SVH

`define IFRAM_AW        11
`define IFRAM_DW        8
`define IFRAM_DEPTH     2048
`define IFRAM_UPW       3
`define IFRAM_FIFO_D    4
`define IFRAM_FIFO_W    19
`define IFRAM_BITS      4'h8
`define IFRAM_ACK_BIT   4'h9
`define IFRAM_TYPE_CODE 4'h6

`endif

// file: hdl/ifram_pkg.sv
// Types shared by the two-wire byte memory slave
package ifram_pkg;

    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_DEV,
        ST_ADDR,
        ST_WDATA,
        ST_RDATA
    } ifram_state_type;

endpackage : ifram_pkg

// file: hdl/ifram_slave.sv
// Two-wire serial slave in front of a 2048 x 8 byte memory
//
// What this block does
// R01: Address writes and random reads use 3 upper plus 8 lower bits, buffered first.
// R02: Sample SDA on SCL rise, change driven SDA on SCL fall.
// R03: SDA is open drain: drive low or release, never drive high.
// R04: Write protect high blocks array writes; low allows every location.
// R05: Reads work at any write protect level.
// R06: Write protect has a pull-down, so open means writes enabled.
// R07: Block is slave only; master starts transfers and always clocks SCL.
// R08: Master changes SDA only while SCL low, except start and stop.
// R09: SDA falling while SCL high is a start and begins a transfer.
// R10: SDA rising while SCL high is a stop; return to standby.
// R11: Writes need no busy time; new command accepted at once, always acked.
// R12: Bytes of 8 bits; on 9th clock sender releases, receiver acks low.
// R13: Stop before a low acknowledge abandons the operation to standby.
// R14: After a not-acknowledge the block releases the bus.
// R15: Device word is 4-bit type, 3 upper address bits, read/write bit.
// R16: Wrong type code means no read or write; stay in standby.
// R17: The 3 bits after the type code are upper memory address bits.
// R18: Eighth device word bit: zero writes, one reads.
// R19: Ack a valid device word, then take and ack the lower address byte.
// R20: Current address read takes no address byte; uses buffered lower bits.
// R21: Data flows in bytes, each received data byte acknowledged low.
// R22: Write bytes go to incrementing addresses, wrapping to 000H.
// R23: Current address read returns last address plus one, wrapping at top.
// R24: Sequential read returns incrementing addresses, wrapping to the first.
// R25: Master ends a read with a not-acknowledge on the last byte.
// R26: SCL and SDA are synchronised, edges found, then decoded.
`timescale 1ns/100ps
`include "ifram_defines.svh"

// ****************************************************************
// Write buffer between the serial side and the array
// ****************************************************************
module ifram_fifo
#(
    parameter int WIDTH = `IFRAM_FIFO_W,
    parameter int DEPTH = `IFRAM_FIFO_D
)
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    wr_ptr_next;
    logic [PW-1:0]    rd_ptr_reg;
    logic [PW-1:0]    rd_ptr_next;
    logic [PW:0]      count_reg;
    logic [PW:0]      count_next;
    logic             push;
    logic             pop;

    assign in_ready  = (count_reg != (PW + 1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = store[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next  = count_reg;
        if (push)
        begin
            wr_ptr_next = (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
        end
        if (pop)
        begin
            rd_ptr_next = (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
        end
        if (push && !pop)
        begin
            count_next = count_reg + 1'b1;
        end
        else if (pop && !push)
        begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
        end
    end

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            store[wr_ptr_reg] <= in_data;
        end
    end
endmodule : ifram_fifo

// ****************************************************************
// Serial slave and memory array
// ****************************************************************
module ifram_slave
    import ifram_pkg::*;
#(
    // Arbitrary neutral type code
    parameter logic [3:0] TYPE_CODE = `IFRAM_TYPE_CODE
)
(
    input  wire logic CLK,
    input  wire logic SYS_RST,
    input  wire logic SCL,
    input  wire logic SDA_I,
    output logic      SDA_O,
    output logic      SDA_OE,
    input  wire logic WP
);
    localparam int AW = `IFRAM_AW;
    localparam int DW = `IFRAM_DW;

    // Address step, wrapping over all eleven bits
    function automatic logic [AW-1:0] next_addr(input logic [AW-1:0] a);
        return a + 1'b1;
    endfunction : next_addr

    // ****************************************************************
    // Input synchronisers and edge detection
    // ****************************************************************
    logic [1:0]         scl_sync_reg;
    logic [1:0]         sda_sync_reg;
    logic [1:0]         wp_sync_reg;
    logic               scl_prev_reg;
    logic               sda_prev_reg;
    logic               scl_s;
    logic               sda_s;
    logic               scl_rise;
    logic               scl_fall;
    logic               start_det;
    logic               stop_det;

    // R26 two-stage synchronisers
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            wp_sync_reg  <= 2'h0;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end
        else
        begin
            scl_sync_reg <= {scl_sync_reg[0], SCL};
            sda_sync_reg <= {sda_sync_reg[0], SDA_I};
            wp_sync_reg  <= {wp_sync_reg[0], WP};
            scl_prev_reg <= scl_sync_reg[1];
            sda_prev_reg <= sda_sync_reg[1];
        end
    end

    assign scl_s    = scl_sync_reg[1];
    assign sda_s    = sda_sync_reg[1];
    // R26 edges on synchronised lines
    assign scl_rise = scl_s && !scl_prev_reg;
    assign scl_fall = !scl_s && scl_prev_reg;
    // R09 start while clock high
    assign start_det = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
    // R10 stop while clock high
    assign stop_det  = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;

    // ****************************************************************
    // Memory array and write buffer
    // ****************************************************************
    logic [DW-1:0]      mem [`IFRAM_DEPTH];
    logic [DW-1:0]      rd_data_reg;
    logic               fifo_in_valid;
    logic               fifo_in_ready;
    logic [AW+DW-1:0]   fifo_in_data;
    logic               fifo_out_valid;
    logic               fifo_out_ready;
    logic [AW+DW-1:0]   fifo_out_data;

    ifram_state_type    state_reg;
    ifram_state_type    state_next;
    logic [AW-1:0]      addr_reg;
    logic [AW-1:0]      addr_next;

    // Draining pauses while a byte is shifted out, trading latency for port calm
    assign fifo_out_ready = (state_reg != ST_RDATA);

    ifram_fifo #(
        .WIDTH (AW + DW),
        .DEPTH (`IFRAM_FIFO_D)
    ) u_fifo (
        .clk       (CLK),
        .rst       (SYS_RST),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // R11 array write lands within cycles, no busy time
    always_ff @(posedge CLK)
    begin
        if (fifo_out_valid && fifo_out_ready)
        begin
            mem[fifo_out_data[AW+DW-1:DW]] <= fifo_out_data[DW-1:0];
        end
        rd_data_reg <= mem[addr_reg];
    end

    // ****************************************************************
    // Protocol engine
    // ****************************************************************
    logic [3:0]         cnt_reg;
    logic [3:0]         cnt_next;
    logic               ackph_reg;
    logic               ackph_next;
    logic [DW-1:0]      shift_reg;
    logic [DW-1:0]      shift_next;
    logic [2:0]         upper_reg;
    logic [2:0]         upper_next;
    logic               oe_reg;
    logic               oe_next;
    logic               push_next;
    logic               push_reg;
    logic [AW+DW-1:0]   pdata_reg;
    logic [AW+DW-1:0]   pdata_next;
    logic               inc_reg;
    logic               inc_next;
    logic [DW-1:0]      last_lo;

    assign fifo_in_valid = push_reg;
    assign fifo_in_data  = pdata_reg;
    // Buffer runs one past the last access once data has moved
    assign last_lo       = addr_reg[DW-1:0] - 8'h01;

    always_comb
    begin
        state_next = state_reg;
        addr_next  = addr_reg;
        cnt_next   = cnt_reg;
        ackph_next = ackph_reg;
        shift_next = shift_reg;
        upper_next = upper_reg;
        oe_next    = oe_reg;
        push_next  = 1'b0;
        pdata_next = pdata_reg;
        inc_next   = inc_reg;
        if (start_det)
        begin
            state_next = ST_DEV;
            cnt_next   = '0;
            ackph_next = 1'b0;
            oe_next    = 1'b0;
        end
        else if (stop_det)
        begin
            // R10 R13 stop ends or abandons the transfer
            state_next = ST_IDLE;
            ackph_next = 1'b0;
            oe_next    = 1'b0;
        end
        else if (state_reg == ST_IDLE)
        begin
            oe_next = 1'b0;
        end
        else if (state_reg == ST_RDATA)
        begin
            if (scl_rise && !ackph_reg)
            begin
                if (cnt_reg == `IFRAM_BITS)
                begin
                    // R14 R25 not-acknowledge releases the bus
                    if (sda_s)
                    begin
                        state_next = ST_IDLE;
                    end
                    cnt_next = `IFRAM_ACK_BIT;
                end
                else
                begin
                    cnt_next = cnt_reg + 4'h1;
                end
            end
            else if (scl_fall)
            begin
                // R02 output changes only after the falling edge
                if (ackph_reg || cnt_reg == `IFRAM_ACK_BIT)
                begin
                    // R05 R24 load next byte, address steps and wraps
                    ackph_next = 1'b0;
                    cnt_next   = '0;
                    shift_next = rd_data_reg;
                    oe_next    = !rd_data_reg[DW-1];
                    addr_next  = next_addr(addr_reg);
                    inc_next   = 1'b1;
                end
                else if (cnt_reg < `IFRAM_BITS)
                begin
                    // R03 a one is sent by releasing
                    shift_next = {shift_reg[DW-2:0], 1'b0};
                    oe_next    = !shift_reg[DW-2];
                end
                else
                begin
                    // R12 transmitter releases for the ninth clock
                    oe_next = 1'b0;
                end
            end
        end
        else
        begin
            if (scl_rise && !ackph_reg && cnt_reg < `IFRAM_BITS)
            begin
                shift_next = {shift_reg[DW-2:0], sda_s};
                cnt_next   = cnt_reg + 4'h1;
            end
            else if (scl_fall && ackph_reg)
            begin
                ackph_next = 1'b0;
                cnt_next   = '0;
                oe_next    = 1'b0;
            end
            else if (scl_fall && cnt_reg == `IFRAM_BITS)
            begin
                ackph_next = 1'b1;
                unique case (state_reg)
                    ST_DEV:
                    begin
                        // R15 R16 type code check
                        if (shift_reg[7:4] == TYPE_CODE)
                        begin
                            // R19 acknowledge the device word
                            oe_next    = 1'b1;
                            // R17 three bits are upper address
                            upper_next = shift_reg[3:1];
                            // R18 last bit chooses read or write
                            if (shift_reg[0])
                            begin
                                // R20 R23 last access plus one, carry reaches upper bits
                                if (inc_reg)
                                begin
                                    addr_next = next_addr({shift_reg[3:1], last_lo});
                                end
                                else
                                begin
                                    addr_next = {shift_reg[3:1], addr_reg[DW-1:0]};
                                end
                                state_next = ST_RDATA;
                            end
                            else
                            begin
                                state_next = ST_ADDR;
                            end
                        end
                        else
                        begin
                            state_next = ST_IDLE;
                        end
                    end
                    ST_ADDR:
                    begin
                        // R01 R19 assemble full address then ack
                        addr_next  = {upper_reg, shift_reg};
                        inc_next   = 1'b0;
                        oe_next    = 1'b1;
                        state_next = ST_WDATA;
                    end
                    ST_WDATA:
                    begin
                        // R04 R06 protected writes are skipped, still acked
                        if (wp_sync_reg[1])
                        begin
                            oe_next   = 1'b1;
                            addr_next = next_addr(addr_reg);
                            inc_next  = 1'b1;
                        end
                        else if (fifo_in_ready)
                        begin
                            // R21 R22 store, ack, step with wrap
                            oe_next    = 1'b1;
                            push_next  = 1'b1;
                            pdata_next = {addr_reg, shift_reg};
                            addr_next  = next_addr(addr_reg);
                            inc_next   = 1'b1;
                        end
                        else
                        begin
                            state_next = ST_IDLE;
                        end
                    end
                    default:
                    begin
                        state_next = ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // State registers
    // ****************************************************************
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            state_reg <= ST_IDLE;
            addr_reg  <= '0;
            cnt_reg   <= '0;
            ackph_reg <= 1'b0;
            shift_reg <= '0;
            upper_reg <= '0;
            oe_reg    <= 1'b0;
            push_reg  <= 1'b0;
            pdata_reg <= '0;
            inc_reg   <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            addr_reg  <= addr_next;
            cnt_reg   <= cnt_next;
            ackph_reg <= ackph_next;
            shift_reg <= shift_next;
            upper_reg <= upper_next;
            oe_reg    <= oe_next;
            push_reg  <= push_next;
            pdata_reg <= pdata_next;
            inc_reg   <= inc_next;
        end
    end

    // R03 R07 the pin is only ever pulled low
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            SDA_O <= 1'b0;
        end
        else
        begin
            SDA_O <= 1'b0;
        end
    end

    assign SDA_OE = oe_reg;
endmodule : ifram_slave

// file: verification/ifram_slave_monitor.sv
// Checker of the slave's pin behaviour on the two-wire link
`timescale 1ns/100ps
module ifram_slave_monitor
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic SCL,
    input wire logic SDA_I,
    input wire logic SDA_O,
    input wire logic SDA_OE,
    input wire logic WP
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);
    // ****************************************************************
    // Bus conditions on the raw pins
    // ****************************************************************
    sequence s_start;
        SCL && $past(SCL) && $fell(SDA_I);
    endsequence
    sequence s_stop;
        SCL && $past(SCL) && $rose(SDA_I);
    endsequence
    // ****************************************************************
    // Properties
    // ****************************************************************
    property p_od;
        SDA_O == 1'b0;
    endproperty
    a_od: assert property (p_od) else $error("sda driven high");
    property p_rst;
        disable iff (1'b0) SYS_RST |=> !SDA_OE;
    endproperty
    a_rst: assert property (p_rst) else $error("sda pulled in reset");
    // Output lags the synchronised clock fall, so the pin was low before
    property p_oe_chg;
        $changed(SDA_OE) |-> !$past(SCL, 1) && !$past(SCL, 2);
    endproperty
    a_oe_chg: assert property (p_oe_chg) else $error("sda moved off scl low");
    property p_oe_hold;
        SCL && $past(SCL) |-> $stable(SDA_OE);
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("sda moved in scl high");
    property p_stop_idle;
        s_stop |-> !SDA_OE [*8];
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("drive after stop");
    property p_start_idle;
        s_start |-> !SDA_OE [*8];
    endproperty
    a_start_idle: assert property (p_start_idle) else $error("drive after start");
    property p_ack_hold;
        $rose(SDA_OE) |-> SDA_OE throughout ##[1:16] $rose(SCL);
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("low not held to rise");
    property p_release;
        $rose(SDA_OE) |-> ##[1:80] $fell(SDA_OE);
    endproperty
    a_release: assert property (p_release) else $error("bus not released");
    c_start: cover property (s_start);
    c_stop: cover property (s_stop);
    c_ack: cover property ($rose(SDA_OE));
    c_wp_ack: cover property (WP && $rose(SDA_OE));
endmodule : ifram_slave_monitor

// file: verification/ifram_host.sv
// Bus master model that clocks and drives the two-wire link
`timescale 1ns/100ps
module ifram_host
(
    output logic      scl,
    output logic      sda_oe,
    input  wire logic sda
);
    initial
    begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    // data moves in low
    // Low phase of 125 ns leaves room for the slave's three-cycle output lag
    // Steps are whole clock periods, so pins move on falling clock edges
    task automatic bit_x(input logic v, output logic s);
        #25.0;
        sda_oe = ~v;
        #100.0;
        scl = 1'b1;
        #50.0;
        s = sda;
        #25.0;
        scl = 1'b0;
    endtask : bit_x
    task automatic start_cond();
        #25.0;
        sda_oe = 1'b0;
        #100.0;
        scl = 1'b1;
        #100.0;
        sda_oe = 1'b1;
        #100.0;
        scl = 1'b0;
    endtask : start_cond
    task automatic stop_cond();
        #25.0;
        sda_oe = 1'b1;
        #100.0;
        scl = 1'b1;
        #100.0;
        sda_oe = 1'b0;
        #200.0;
    endtask : stop_cond
    task automatic xfer(input logic [7:0] b, input int n, output logic [7:0] r);
        logic s;
        r = 8'h00;
        for (int i = 7; i > 7 - n; i--)
        begin
            bit_x(b[i], s);
            r[i] = s;
        end
    endtask : xfer
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic [7:0] r;
        xfer(b, 8, r);
        bit_x(1'b1, ack);
    endtask : wbyte
    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic s;
        xfer(8'hFF, 8, d);
        bit_x(nack, s);
    endtask : rbyte
endmodule : ifram_host

// file: verification/ifram_slave_tb.sv
// Self-checking bench of the two-wire byte memory slave
`timescale 1ns/100ps
module ifram_slave_tb;
    // Arbitrary neutral type code, matched to the slave
    localparam logic [3:0] TC = 4'h6;
    logic        clk;
    logic        sys_rst;
    logic        wp;
    wire logic   scl;
    wire logic   host_oe;
    wire logic   sda_o;
    wire logic   sda_oe;
    // Open drain wire with pull-up
    wire logic   sda = (sda_oe | host_oe) ? 1'b0 : 1'b1;
    int          fails;
    int          checks;
    int          cyc;
    integer      seed;
    logic [7:0]  mem_m [0:2047];
    logic [10:0] last;
    ifram_slave #(.TYPE_CODE(TC)) ifram_slave_inst
    (
        .CLK(clk), .SYS_RST(sys_rst), .SCL(scl), .SDA_I(sda),
        .SDA_O(sda_o), .SDA_OE(sda_oe), .WP(wp)
    );
    ifram_host ifram_host_inst (.scl(scl), .sda_oe(host_oe), .sda(sda));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [10:0] a, input int n, input logic wpv);
        logic       ack;
        logic [7:0] d;
        @(negedge clk);
        wp <= wpv;
        ifram_host_inst.start_cond();
        ifram_host_inst.wbyte({TC, a[10:8], 1'b0}, ack);
        chk("dev ack", 8'h00, 8'(ack));
        ifram_host_inst.wbyte(a[7:0], ack);
        chk("addr ack", 8'h00, 8'(ack));
        for (int i = 0; i < n; i++)
        begin
            d = 8'($random(seed));
            ifram_host_inst.wbyte(d, ack);
            chk("data ack", 8'h00, 8'(ack));
            if (!wpv)
                mem_m[a + 11'(i)] = d;
            last = a + 11'(i);
        end
        ifram_host_inst.stop_cond();
    endtask : wr
    task automatic rd(input logic [10:0] a, input int n, input logic cur);
        logic        ack;
        logic [7:0]  d;
        logic [10:0] ad;
        ad = cur ? {a[10:8], last[7:0]} + 11'h001 : a;
        ifram_host_inst.start_cond();
        if (!cur)
        begin
            ifram_host_inst.wbyte({TC, a[10:8], 1'b0}, ack);
            chk("dev ack", 8'h00, 8'(ack));
            ifram_host_inst.wbyte(a[7:0], ack);
            chk("addr ack", 8'h00, 8'(ack));
            ifram_host_inst.start_cond();
        end
        ifram_host_inst.wbyte({TC, a[10:8], 1'b1}, ack);
        chk("rd ack", 8'h00, 8'(ack));
        for (int i = 0; i < n; i++)
        begin
            ifram_host_inst.rbyte(i == n - 1, d);
            chk("rd data", mem_m[ad], d);
            last = ad;
            ad = ad + 11'h001;
        end
        ifram_host_inst.stop_cond();
    endtask : rd
    task automatic partial(input logic [10:0] a);
        logic       ack;
        logic [7:0] r;
        ifram_host_inst.start_cond();
        ifram_host_inst.wbyte({TC, a[10:8], 1'b0}, ack);
        ifram_host_inst.wbyte(a[7:0], ack);
        // Half a byte, then stop: nothing may be stored
        ifram_host_inst.xfer(8'h00, 4, r);
        ifram_host_inst.stop_cond();
    endtask : partial
    task automatic bad_type();
        logic ack;
        for (int k = 0; k < 4; k++)
        begin
            ifram_host_inst.start_cond();
            ifram_host_inst.wbyte({TC ^ (4'h1 << k), 4'h0}, ack);
            chk("bad type nack", 8'h01, 8'(ack));
            ifram_host_inst.stop_cond();
        end
    endtask : bad_type
    task end_sim();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    // Ceiling over twice the seven to nine thousand cycles the tests need
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            $display("timeout at cycle %0d", cyc);
            end_sim();
        end
    end
    initial
    begin
        logic [10:0] ra;
        int          rn;
        seed = 32'h9AF89EE4;
        fails = 0;
        checks = 0;
        cyc = 0;
        wp = 1'b0;
        sys_rst = 1'b1;
        last = 11'h000;
        repeat (6) @(posedge clk);
        @(negedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(negedge clk);
        wr(11'h7FE, 4, 1'b0);
        rd(11'h7FE, 3, 1'b0);
        rd(11'h000, 1, 1'b1);
        wr(11'h0FE, 3, 1'b0);
        rd(11'h0FE, 2, 1'b0);
        rd(11'h000, 1, 1'b1);
        $display("test wrap done");
        wr(11'h120, 4, 1'b0);
        partial(11'h123);
        wr(11'h121, 2, 1'b1);
        rd(11'h120, 4, 1'b0);
        $display("test protect done");
        bad_type();
        wr(11'h355, 2, 1'b0);
        rd(11'h355, 2, 1'b0);
        $display("test type done");
        for (int k = 0; k < 4; k++)
        begin
            ra = 11'($random(seed));
            rn = ($random(seed) & 3) + 1;
            wr(ra, rn, 1'b0);
            rd(ra, rn, 1'b0);
        end
        $display("test random done");
        end_sim();
    end
endmodule : ifram_slave_tb
bind ifram_slave ifram_slave_monitor ifram_slave_monitor_inst
(
    .CLK(CLK), .SYS_RST(SYS_RST), .SCL(SCL), .SDA_I(SDA_I),
    .SDA_O(SDA_O), .SDA_OE(SDA_OE), .WP(WP)
);
